// >>> hdl/break_defs.svh
// Register offsets, field positions, reset values and sizes of the break comparator
`ifndef BREAK_DEFS_SVH
`define BREAK_DEFS_SVH
`define OFS_VALUE_A  8'h00
`define OFS_MASK_A   8'h04
`define OFS_FILTER_A 8'h08
`define OFS_VALUE_B  8'h0C
`define OFS_MASK_B   8'h10
`define OFS_FILTER_B 8'h14
`define OFS_DATA_B   8'h18
`define OFS_DMASK_B  8'h1C
`define OFS_CTRL     8'h20
`define OFS_COUNT    8'h24
`define OFS_STATUS   8'h28
`define OFS_IRQ_MASK 8'h2C
`define PAGE_SRC     4'h3
`define PAGE_DST     4'h4
`define RST_WORD     32'h0000_0000
`define RST_FILTER   8'h00
`define RST_CTRL     6'h00
`define RST_COUNT    12'h000
`define FLT_WIDTH    8
`define FLT_BUS      7:6
`define FLT_KIND     5:4
`define FLT_DIR      3:2
`define FLT_SIZE     1:0
`define CTL_WIDTH    6
`define CTL_SEQ      0
`define CTL_AFTER_A  1
`define CTL_AFTER_B  2
`define CTL_DATA_EN  3
`define CTL_DATA_IDB 4
`define CTL_REPEAT   5
`define CNT_WIDTH    12
`define ST_WIDTH     2
`define ST_A         0
`define ST_B         1
`define NUM_BRANCH   4
`endif

// >>> hdl/break_pkg.sv
// Types shared by the break comparator modules
`default_nettype none
`include "break_defs.svh"
package break_pkg;
  typedef logic [31:0] word_t;
  typedef logic [`FLT_WIDTH-1:0] filter_t;
  typedef enum logic [1:0] {
    BUS_NONE  = 2'h0,
    BUS_L     = 2'h1,
    BUS_I     = 2'h2,
    BUS_L_ALT = 2'h3
  } bus_sel_e;
  typedef struct packed {
    word_t                         value_a;
    word_t                         mask_a;
    filter_t                       filter_a;
    word_t                         value_b;
    word_t                         mask_b;
    filter_t                       filter_b;
    word_t                         data_b;
    word_t                         dmask_b;
    logic [`CTL_WIDTH-1:0]         ctrl;
    logic [`CNT_WIDTH-1:0]         count;
    logic [`ST_WIDTH-1:0]          status;
    logic [`ST_WIDTH-1:0]          irq_mask;
    logic                          armed;
    logic                          pend_a;
    logic                          pend_b;
    logic [`NUM_BRANCH-1:0][31:0]  src;
    logic [`NUM_BRANCH-1:0][31:0]  dst;
    word_t                         rdata;
    logic                          irq;
  } state_s;
endpackage
`default_nettype wire

// >>> hdl/break_channel.sv
// One break channel: compares an observed bus cycle with its programmed condition
`default_nettype none
`include "break_defs.svh"
module break_channel #(
  parameter bit HAS_DATA = 1'b0
) (
  // Programmed condition
  input  wire break_pkg::word_t   value,
  input  wire break_pkg::word_t   mask,
  input  wire break_pkg::filter_t filter,
  input  wire break_pkg::word_t   data_value,
  input  wire break_pkg::word_t   data_mask,
  input  wire logic               data_en,
  input  wire logic               data_from_idb,
  // Observed bus cycle
  input  wire logic               cyc_valid,
  input  wire logic               cyc_on_i_bus,
  input  wire logic               cyc_fetch,
  input  wire logic               cyc_write,
  input  wire logic [1:0]         cyc_size,
  input  wire break_pkg::word_t   l_bus_address,
  input  wire break_pkg::word_t   i_bus_address,
  input  wire break_pkg::word_t   logic_data_bus,
  input  wire break_pkg::word_t   internal_data_bus,
  // Result
  output logic                    match
);
  import break_pkg::*;

  bus_sel_e bus_sel;
  word_t    addr_sel;
  word_t    data_sel;
  logic     bus_ok;
  logic     kind_ok;
  logic     dir_ok;
  logic     size_ok;
  logic     addr_ok;
  logic     data_ok;

  // Field checks; a kind, direction or size field left at its no-compare code never blocks a match, but bus code 0 does
  always_comb begin
    bus_sel  = bus_sel_e'(filter[`FLT_BUS]);
    addr_sel = (bus_sel == BUS_I) ? i_bus_address : l_bus_address;
    data_sel = data_from_idb ? internal_data_bus : logic_data_bus;
    case (bus_sel)
      BUS_NONE: bus_ok = 1'b0; // No bus chosen, so no address to compare
      BUS_I:    bus_ok = cyc_on_i_bus;
      default:  bus_ok = !cyc_on_i_bus;
    endcase
    case (filter[`FLT_KIND])
      2'h1:    kind_ok = cyc_fetch;
      2'h2:    kind_ok = !cyc_fetch;
      default: kind_ok = 1'b1;
    endcase
    case (filter[`FLT_DIR])
      2'h1:    dir_ok = !cyc_write;
      2'h2:    dir_ok = cyc_write;
      default: dir_ok = 1'b1;
    endcase
    size_ok = (filter[`FLT_SIZE] == 2'h0) || (filter[`FLT_SIZE] == cyc_size);
    addr_ok = ((addr_sel ^ value) & ~mask) == 32'h0000_0000;
    data_ok = !HAS_DATA || !data_en ||
              (((data_sel ^ data_value) & ~data_mask) == 32'h0000_0000);
    match   = cyc_valid && bus_ok && kind_ok && dir_ok && size_ok && addr_ok && data_ok;
  end
endmodule
`default_nettype wire

// >>> hdl/user_break_controller.sv
// Two-channel user break comparator with register port and break interrupt
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`default_nettype none
`include "break_defs.svh"
module user_break_controller (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  // Register port
  input  wire logic [7:0]              reg_addr,
  input  wire break_pkg::word_t        reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output break_pkg::word_t             reg_rdata,
  // Observed processor bus cycle
  input  wire logic                    cyc_valid,
  input  wire logic                    cyc_on_i_bus,
  input  wire logic                    cyc_fetch,
  input  wire logic                    cyc_write,
  input  wire logic [1:0]              cyc_size,
  input  wire break_pkg::word_t        l_bus_address,
  input  wire break_pkg::word_t        i_bus_address,
  input  wire break_pkg::word_t        logic_data_bus,
  input  wire break_pkg::word_t        internal_data_bus,
  // Instruction retire and branch report
  input  wire logic                    insn_retired,
  input  wire logic                    branch_valid,
  input  wire break_pkg::word_t        branch_src,
  input  wire break_pkg::word_t        branch_dst,
  // Interrupt request
  output logic                         break_irq
);
  import break_pkg::*;

  state_s                  st_reg;
  state_s                  st_next;
  logic                    match_a;
  logic                    match_b;
  logic                    a_live;
  logic                    b_live;
  logic                    ev_a;
  logic                    ev_b;
  logic [`ST_WIDTH-1:0]    st_clear;

  ////////////////////////////////////////////////////////////////////////////
  // Channel comparators

  // Channel A has no data compare, so its data inputs are tied off
  break_channel #(.HAS_DATA(1'b0)) u_chan_a (
    .value             (st_reg.value_a),
    .mask              (st_reg.mask_a),
    .filter            (st_reg.filter_a),
    .data_value        (32'h0000_0000),
    .data_mask         (32'hFFFF_FFFF),
    .data_en           (1'b0),
    .data_from_idb     (1'b0),
    .cyc_valid         (cyc_valid),
    .cyc_on_i_bus      (cyc_on_i_bus),
    .cyc_fetch         (cyc_fetch),
    .cyc_write         (cyc_write),
    .cyc_size          (cyc_size),
    .l_bus_address     (l_bus_address),
    .i_bus_address     (i_bus_address),
    .logic_data_bus    (logic_data_bus),
    .internal_data_bus (internal_data_bus),
    .match             (match_a)
  );

  // Channel B adds the masked data compare
  break_channel #(.HAS_DATA(1'b1)) u_chan_b (
    .value             (st_reg.value_b),
    .mask              (st_reg.mask_b),
    .filter            (st_reg.filter_b),
    .data_value        (st_reg.data_b),
    .data_mask         (st_reg.dmask_b),
    .data_en           (st_reg.ctrl[`CTL_DATA_EN]),
    .data_from_idb     (st_reg.ctrl[`CTL_DATA_IDB]),
    .cyc_valid         (cyc_valid),
    .cyc_on_i_bus      (cyc_on_i_bus),
    .cyc_fetch         (cyc_fetch),
    .cyc_write         (cyc_write),
    .cyc_size          (cyc_size),
    .l_bus_address     (l_bus_address),
    .i_bus_address     (i_bus_address),
    .logic_data_bus    (logic_data_bus),
    .internal_data_bus (internal_data_bus),
    .match             (match_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Register access, break sequencing, branch capture and interrupt
  always_comb begin
    st_next       = st_reg;
    st_next.rdata = 32'h0000_0000; // Read data stand for one cycle only
    a_live        = 1'b0;
    b_live        = 1'b0;
    ev_a          = 1'b0;
    ev_b          = 1'b0;
    st_clear      = '0;

    // Software writes; narrow registers drop the upper write bits
    if (reg_wr) begin
      case (reg_addr)
        `OFS_VALUE_A:  st_next.value_a  = reg_wdata;
        `OFS_MASK_A:   st_next.mask_a   = reg_wdata;
        `OFS_FILTER_A: st_next.filter_a = reg_wdata[`FLT_WIDTH-1:0];
        `OFS_VALUE_B:  st_next.value_b  = reg_wdata;
        `OFS_MASK_B:   st_next.mask_b   = reg_wdata;
        `OFS_FILTER_B: st_next.filter_b = reg_wdata[`FLT_WIDTH-1:0];
        `OFS_DATA_B:   st_next.data_b   = reg_wdata;
        `OFS_DMASK_B:  st_next.dmask_b  = reg_wdata;
        `OFS_CTRL:     st_next.ctrl     = reg_wdata[`CTL_WIDTH-1:0];
        `OFS_COUNT:    st_next.count    = reg_wdata[`CNT_WIDTH-1:0];
        `OFS_IRQ_MASK: st_next.irq_mask = reg_wdata[`ST_WIDTH-1:0];
        default: ;
      endcase
    end

    // Software reads; unmapped or unaligned addresses return zero
    if (reg_rd) begin
      case (reg_addr)
        `OFS_VALUE_A:  st_next.rdata = st_reg.value_a;
        `OFS_MASK_A:   st_next.rdata = st_reg.mask_a;
        `OFS_FILTER_A: st_next.rdata = {24'h00_0000, st_reg.filter_a};
        `OFS_VALUE_B:  st_next.rdata = st_reg.value_b;
        `OFS_MASK_B:   st_next.rdata = st_reg.mask_b;
        `OFS_FILTER_B: st_next.rdata = {24'h00_0000, st_reg.filter_b};
        `OFS_DATA_B:   st_next.rdata = st_reg.data_b;
        `OFS_DMASK_B:  st_next.rdata = st_reg.dmask_b;
        `OFS_CTRL:     st_next.rdata = {26'h000_0000, st_reg.ctrl};
        `OFS_COUNT:    st_next.rdata = {20'h0_0000, st_reg.count};
        `OFS_IRQ_MASK: st_next.rdata = {30'h0000_0000, st_reg.irq_mask};
        `OFS_STATUS: begin
          st_next.rdata = {30'h0000_0000, st_reg.status};
          st_clear      = st_reg.status; // Reading the status clears it
        end
        default: begin
          if (reg_addr[1:0] == 2'h0 && reg_addr[7:4] == `PAGE_SRC) begin
            st_next.rdata = st_reg.src[reg_addr[3:2]];
          end else if (reg_addr[1:0] == 2'h0 && reg_addr[7:4] == `PAGE_DST) begin
            st_next.rdata = st_reg.dst[reg_addr[3:2]];
          end
        end
      endcase
    end

    // Independent or sequential use of the two channels
    if (st_reg.ctrl[`CTL_SEQ]) begin
      b_live = match_b && st_reg.armed;
      if (b_live) begin
        st_next.armed = 1'b0;
      end
      // Arming takes effect next cycle, so a B hit in the same cycle never counts
      if (match_a) begin
        st_next.armed = 1'b1;
      end
    end else begin
      a_live        = match_a;
      b_live        = match_b;
      st_next.armed = 1'b0;
    end

    // Hardware count-down overrides a software write in the same cycle
    if (b_live && st_reg.ctrl[`CTL_REPEAT]) begin
      if (st_reg.count > 12'h001) begin
        st_next.count = st_reg.count - 12'h001;
        b_live        = 1'b0;
      end else begin
        st_next.count = `RST_COUNT;
      end
    end

    // After-execution breaks wait for the next retire; assumes in-order retire
    if (st_reg.pend_a && insn_retired) begin
      ev_a           = 1'b1;
      st_next.pend_a = 1'b0;
    end
    if (a_live && cyc_fetch && st_reg.ctrl[`CTL_AFTER_A]) begin
      st_next.pend_a = 1'b1;
    end else if (a_live) begin
      ev_a = 1'b1;
    end
    if (st_reg.pend_b && insn_retired) begin
      ev_b           = 1'b1;
      st_next.pend_b = 1'b0;
    end
    if (b_live && cyc_fetch && st_reg.ctrl[`CTL_AFTER_B]) begin
      st_next.pend_b = 1'b1;
    end else if (b_live) begin
      ev_b = 1'b1;
    end

    // Sticky status: a new event beats the read that clears it
    st_next.status = (st_reg.status & ~st_clear) | {ev_b, ev_a};
    st_next.irq    = |(st_next.status & st_next.irq_mask);

    // Branch buffer, newest pair at index 0
    if (branch_valid) begin
      st_next.src = {st_reg.src[`NUM_BRANCH-2:0], branch_src};
      st_next.dst = {st_reg.dst[`NUM_BRANCH-2:0], branch_dst};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Everything clears at reset, including the branch buffer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg          <= '0;
      st_reg.value_a  <= `RST_WORD;
      st_reg.mask_a   <= `RST_WORD;
      st_reg.filter_a <= `RST_FILTER;
      st_reg.ctrl     <= `RST_CTRL;
      st_reg.count    <= `RST_COUNT;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign break_irq = st_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_irq_level;
    break_irq == |(st_reg.status & st_reg.irq_mask);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level disagrees with masked status");

  property p_read_clears;
    reg_rd && reg_addr == `OFS_STATUS && !ev_a && !ev_b |=> st_reg.status == 2'h0;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status read without events did not clear status");

  property p_reserved_zero;
    reg_rd && reg_addr == `OFS_FILTER_A |=> reg_rdata == {24'h00_0000, $past(st_reg.filter_a)};
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bus-cycle bits read nonzero");

  property p_value_a_write;
    reg_wr && reg_addr == `OFS_VALUE_A |=> st_reg.value_a == $past(reg_wdata);
  endproperty
  a_value_a_write: assert property (p_value_a_write)
    else $error("channel A address value did not take the write");

  property p_addr_compare;
    match_a |-> (((st_reg.filter_a[`FLT_BUS] == 2'h2 ? i_bus_address : l_bus_address)
                 ^ st_reg.value_a) & ~st_reg.mask_a) == 32'h0000_0000;
  endproperty
  a_addr_compare: assert property (p_addr_compare)
    else $error("channel A matched with an unmasked address bit differing");

  property p_before_break;
    !st_reg.ctrl[`CTL_SEQ] && match_a && !(cyc_fetch && st_reg.ctrl[`CTL_AFTER_A])
      |=> st_reg.status[`ST_A] ##1 break_irq || !st_reg.irq_mask[`ST_A] || $past(reg_rd);
  endproperty
  a_before_break: assert property (p_before_break)
    else $error("before-execution break on channel A not flagged");

  property p_seq_order;
    st_reg.ctrl[`CTL_SEQ] && match_b && !st_reg.armed && !st_reg.pend_b
      && !st_reg.status[`ST_B] |=> !st_reg.status[`ST_B];
  endproperty
  a_seq_order: assert property (p_seq_order)
    else $error("sequential break taken without an earlier channel A match");

  property p_repeat;
    !st_reg.ctrl[`CTL_SEQ] && st_reg.ctrl[`CTL_REPEAT] && match_b && st_reg.count > 12'h001
      |=> st_reg.count == $past(st_reg.count) - 12'h001 && !$rose(st_reg.pend_b);
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("repeat count did not step down on a channel B match");

  property p_branch;
    branch_valid |=> st_reg.src[0] == $past(branch_src) && st_reg.dst[0] == $past(branch_dst)
      && st_reg.src[1] == $past(st_reg.src[0]);
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch pair not captured at the head of the buffer");

  // Field decoding as seen on the channel A match
  property p_bus_off;
    st_reg.filter_a[`FLT_BUS] == 2'h0 |-> !match_a;
  endproperty
  a_bus_off: assert property (p_bus_off)
    else $error("channel A matched with its bus field off");

  property p_fetch_only;
    match_a && st_reg.filter_a[`FLT_KIND] == 2'h1 |-> cyc_fetch;
  endproperty
  a_fetch_only: assert property (p_fetch_only)
    else $error("fetch-only condition matched a data access");

  property p_write_only;
    match_a && st_reg.filter_a[`FLT_DIR] == 2'h2 |-> cyc_write;
  endproperty
  a_write_only: assert property (p_write_only)
    else $error("write-only condition matched a read cycle");

  property p_size_agree;
    match_a && st_reg.filter_a[`FLT_SIZE] != 2'h0 |-> cyc_size == st_reg.filter_a[`FLT_SIZE];
  endproperty
  a_size_agree: assert property (p_size_agree)
    else $error("size condition matched a cycle of another size");

  property p_repeat_end;
    !st_reg.ctrl[`CTL_SEQ] && st_reg.ctrl[`CTL_REPEAT] && match_b && st_reg.count <= 12'h001
      |=> st_reg.count == 12'h000;
  endproperty
  a_repeat_end: assert property (p_repeat_end)
    else $error("repeat count not emptied by the breaking hit");

  property p_seq_no_a;
    st_reg.ctrl[`CTL_SEQ] && !st_reg.pend_a && !st_reg.status[`ST_A] |=> !st_reg.status[`ST_A];
  endproperty
  a_seq_no_a: assert property (p_seq_no_a)
    else $error("channel A broke on its own in sequential mode");
endmodule
`default_nettype wire

// >>> tb/core_bus_model.sv
// Behavioural processor core: bus cycles, instruction retire and branch reports
`default_nettype none
module core_bus_model (
  // Clock
  input  wire logic              clock,
  // Observed bus cycle
  output logic                   cyc_valid,
  output logic                   cyc_on_i_bus,
  output logic                   cyc_fetch,
  output logic                   cyc_write,
  output logic [1:0]             cyc_size,
  output break_pkg::word_t       l_bus_address,
  output break_pkg::word_t       i_bus_address,
  output break_pkg::word_t       logic_data_bus,
  output break_pkg::word_t       internal_data_bus,
  // Retire and branch report
  output logic                   insn_retired,
  output logic                   branch_valid,
  output break_pkg::word_t       branch_src,
  output break_pkg::word_t       branch_dst
);
  timeunit 1ns;
  timeprecision 1ps;
  import break_pkg::*;

  // Quiet bus at time zero
  initial begin
    {cyc_valid, cyc_on_i_bus, cyc_fetch, cyc_write, cyc_size} = '0;
    {l_bus_address, i_bus_address, logic_data_bus, internal_data_bus} = '0;
    {insn_retired, branch_valid, branch_src, branch_dst} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One bus cycle; afterwards the buses show inverted values, never the last one
  task automatic cycle(input logic on_i, input logic fetch, input logic wr,
                       input logic [1:0] sz, input word_t la, input word_t ia,
                       input word_t ld, input word_t id);
    @(posedge clock);
    cyc_valid         <= 1'b1;
    cyc_on_i_bus      <= on_i;
    cyc_fetch         <= fetch;
    cyc_write         <= wr;
    cyc_size          <= sz;
    l_bus_address     <= la;
    i_bus_address     <= ia;
    logic_data_bus    <= ld;
    internal_data_bus <= id;
    @(posedge clock);
    cyc_valid         <= 1'b0;
    cyc_size          <= ~sz;
    l_bus_address     <= ~la;
    i_bus_address     <= ~ia;
    logic_data_bus    <= ~ld;
    internal_data_bus <= ~id;
  endtask

  // One-cycle retire pulse
  task automatic retire();
    @(posedge clock);
    insn_retired <= 1'b1;
    @(posedge clock);
    insn_retired <= 1'b0;
  endtask

  // One branch report; the pair is scrambled once the pulse is over
  task automatic branch(input word_t s, input word_t d);
    @(posedge clock);
    branch_valid <= 1'b1;
    branch_src   <= s;
    branch_dst   <= d;
    @(posedge clock);
    branch_valid <= 1'b0;
    branch_src   <= ~s;
    branch_dst   <= ~d;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_user_break_controller.sv
// Self-checking testbench of the two-channel break comparator
`default_nettype none
`include "break_defs.svh"
module tb_user_break_controller;
  timeunit 1ns;
  timeprecision 1ps;
  import break_pkg::*;

  logic        clock, rst_n, reg_wr, reg_rd, break_irq;
  logic [7:0]  reg_addr;
  word_t       reg_wdata, reg_rdata, la, ia, ld, id, bs, bd;
  logic        cv, ci, cf, cw, ir, bv;
  logic [1:0]  cs;
  int          n_fail, samples_checked;

  core_bus_model bus (.clock(clock), .cyc_valid(cv), .cyc_on_i_bus(ci), .cyc_fetch(cf),
    .cyc_write(cw), .cyc_size(cs), .l_bus_address(la), .i_bus_address(ia),
    .logic_data_bus(ld), .internal_data_bus(id), .insn_retired(ir), .branch_valid(bv),
    .branch_src(bs), .branch_dst(bd));

  user_break_controller dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cyc_valid(cv), .cyc_on_i_bus(ci), .cyc_fetch(cf), .cyc_write(cw), .cyc_size(cs),
    .l_bus_address(la), .i_bus_address(ia), .logic_data_bus(ld),
    .internal_data_bus(id), .insn_retired(ir), .branch_valid(bv), .branch_src(bs),
    .branch_dst(bd), .break_irq(break_irq));

  // Free-running 50 MHz clock
  always #10 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////////
  // Register port and comparison helpers
  task automatic wr(input logic [7:0] a, input word_t d);
    @(posedge clock);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output word_t d);
    @(posedge clock);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic check(input string what, input word_t exp, input word_t got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic check_flag(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input word_t exp, input string what);
    word_t d;
    rd(a, d);
    check(what, exp, d);
  endtask

  // Cycle with the address on the chosen bus and its inverse on the other one
  task automatic hit(input logic on_i, input logic f, input logic w, input logic [1:0] sz,
                     input word_t a);
    bus.cycle(on_i, f, w, sz, on_i ? ~a : a, on_i ? a : ~a, '0, '0);
  endtask

  // Program filter A, run one cycle, then read and clear the status
  task automatic a_try(input filter_t f, input logic on_i, input logic fe, input logic w,
                       input logic [1:0] sz, input word_t a, input logic exp, input string s);
    word_t d;
    wr(`OFS_FILTER_A, {24'h0, f});
    hit(on_i, fe, w, sz, a);
    rd(`OFS_STATUS, d);
    check_flag(s, exp, d[`ST_A]);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    rdchk(`OFS_VALUE_A, 32'h0000_0000, "value_a reset");
    rdchk(`OFS_MASK_A, 32'h0000_0000, "mask_a reset");
    rdchk(`OFS_FILTER_A, 32'h0000_0000, "filter_a reset");
    wr(`OFS_VALUE_A, 32'hA5C3_0F96);
    rdchk(`OFS_VALUE_A, 32'hA5C3_0F96, "value_a");
    wr(`OFS_MASK_A, 32'h5A3C_F069);
    rdchk(`OFS_MASK_A, 32'h5A3C_F069, "mask_a");
    wr(`OFS_FILTER_A, 32'h0000_00FF);
    rdchk(`OFS_FILTER_A, 32'h0000_00FF, "filter_a upper");
    rdchk(8'h50, 32'h0000_0000, "unmapped");
  endtask

  // Every code of every filter field against matching and differing cycles
  task automatic t_fields();
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_VALUE_A, 32'h1234_5000);
    wr(`OFS_MASK_A, 32'h0);
    for (int c = 0; c < 4; c++) begin
      for (int b = 0; b < 2; b++) begin
        a_try({c[1:0], 6'h0}, b[0], 1'b0, 1'b0, 2'b11, 32'h1234_5000,
              b ? (c == 2) : c[0], "bus select");
        a_try({2'b01, c[1:0], 4'h0}, 1'b0, b[0], 1'b0, 2'b11, 32'h1234_5000,
              c == 0 || c == 3 || (b ? c == 1 : c == 2), "fetch or data");
        a_try({4'h4, c[1:0], 2'b00}, 1'b0, 1'b0, b[0], 2'b11, 32'h1234_5000,
              c == 0 || c == 3 || (b ? c == 2 : c == 1), "direction");
      end
      for (int z = 1; z < 4; z++)
        a_try({6'h10, c[1:0]}, 1'b0, 1'b0, 1'b0, z[1:0], 32'h1234_5000,
              c == 0 || c == z, "operand size");
    end
    wr(`OFS_MASK_A, 32'h0000_0FFF);
    a_try(8'h40, 1'b0, 1'b0, 1'b0, 2'b01, 32'h1234_5ABC, 1'b1, "masked page");
    a_try(8'h40, 1'b0, 1'b0, 1'b0, 2'b01, 32'h1234_4000, 1'b0, "bit 12 kept");
    wr(`OFS_MASK_A, 32'h8000_0000);
    a_try(8'h40, 1'b0, 1'b0, 1'b0, 2'b10, 32'h9234_5000, 1'b1, "top bit masked");
  endtask

  // Interrupt raised, cleared by the status read, and held off by the mask
  task automatic t_irq();
    wr(`OFS_IRQ_MASK, 32'h1);
    wr(`OFS_MASK_A, 32'h0);
    wr(`OFS_FILTER_A, 32'h40);
    hit(1'b0, 1'b0, 1'b0, 2'b11, 32'h1234_5000);
    repeat (3) @(posedge clock);
    #1 check_flag("break_irq raised", 1'b1, break_irq);
    rdchk(`OFS_STATUS, 32'h1, "status a");
    repeat (2) @(posedge clock);
    #1 check_flag("break_irq cleared", 1'b0, break_irq);
    wr(`OFS_IRQ_MASK, 32'h0);
    hit(1'b0, 1'b0, 1'b0, 2'b11, 32'h1234_5000);
    repeat (3) @(posedge clock);
    #1 check_flag("break_irq masked", 1'b0, break_irq);
    rdchk(`OFS_STATUS, 32'h1, "status a masked");
  endtask

  // Channel B data compare from either data bus, then sequential mode
  task automatic t_chan_b();
    wr(`OFS_FILTER_A, 32'h0);
    wr(`OFS_VALUE_B, 32'h0000_8000);
    wr(`OFS_FILTER_B, 32'h40);
    wr(`OFS_DATA_B, 32'hCAFE_0000);
    wr(`OFS_DMASK_B, 32'h0000_FFFF);
    wr(`OFS_CTRL, 32'h18);
    bus.cycle(1'b0, 1'b0, 1'b0, 2'b11, 32'h8000, 32'h0, 32'h1111_1111, 32'hCAFE_1234);
    rdchk(`OFS_STATUS, 32'h2, "data b internal");
    bus.cycle(1'b0, 1'b0, 1'b0, 2'b11, 32'h8000, 32'h0, 32'hCAFE_1234, 32'h1111_1111);
    rdchk(`OFS_STATUS, 32'h0, "data b other bus");
    wr(`OFS_CTRL, 32'h08);
    bus.cycle(1'b0, 1'b0, 1'b0, 2'b11, 32'h8000, 32'h0, 32'hCAFE_1234, 32'h1111_1111);
    rdchk(`OFS_STATUS, 32'h2, "data b logic");
    wr(`OFS_CTRL, 32'h01);
    wr(`OFS_FILTER_A, 32'h40);
    hit(1'b0, 1'b0, 1'b0, 2'b11, 32'h8000);
    rdchk(`OFS_STATUS, 32'h0, "sequence b alone");
    hit(1'b0, 1'b0, 1'b0, 2'b11, 32'h1234_5000);
    hit(1'b0, 1'b0, 1'b0, 2'b11, 32'h8000);
    rdchk(`OFS_STATUS, 32'h2, "sequence a then b");
  endtask

  // Repeat count, after-execution fetch break and branch history
  task automatic t_rest();
    wr(`OFS_CTRL, 32'h20);
    wr(`OFS_COUNT, 32'h2);
    hit(1'b0, 1'b0, 1'b0, 2'b11, 32'h8000);
    rdchk(`OFS_STATUS, 32'h0, "repeat first hit");
    rdchk(`OFS_COUNT, 32'h1, "repeat count");
    hit(1'b0, 1'b0, 1'b0, 2'b11, 32'h8000);
    rdchk(`OFS_STATUS, 32'h2, "repeat last hit");
    wr(`OFS_CTRL, 32'h02);
    wr(`OFS_FILTER_A, 32'h50);
    hit(1'b0, 1'b1, 1'b0, 2'b11, 32'h1234_5000);
    rdchk(`OFS_STATUS, 32'h0, "after exec held");
    bus.retire();
    rdchk(`OFS_STATUS, 32'h1, "after exec released");
    wr(`OFS_CTRL, 32'h04);
    wr(`OFS_FILTER_B, 32'h50);
    wr(`OFS_IRQ_MASK, 32'h2);
    hit(1'b0, 1'b1, 1'b0, 2'b11, 32'h8000);
    rdchk(`OFS_STATUS, 32'h0, "b after exec held");
    bus.retire();
    repeat (2) @(posedge clock);
    #1 check_flag("break_irq b", 1'b1, break_irq);
    rdchk(`OFS_STATUS, 32'h2, "b after exec released");
    for (int i = 0; i < 5; i++) bus.branch(32'h100 + i, 32'h200 + i);
    for (int k = 0; k < 4; k++) begin
      rdchk(8'h30 + 8'(4 * k), 32'h104 - k, "branch source");
      rdchk(8'h40 + 8'(4 * k), 32'h204 - k, "branch dest");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    final_report();
  end

  // Main sequence
  initial begin
    clock = 1'b0; rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = '0; reg_wdata = '0; n_fail = 0; samples_checked = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_fields();
    t_irq();
    t_chan_b();
    t_rest();
    final_report();
  end
endmodule
`default_nettype wire
